// ---- hdl/rtu_fifo.sv ----
// small synchronous fifo with valid/ready on both sides
`timescale 1ns/100ps
module rtu_fifo #(
  parameter int WIDTH = 9,
  parameter int DEPTH = 8
) (
  input wire logic clk,
  input wire logic rst_b,
  input wire logic in_valid,
  output logic in_ready,
  input wire logic [WIDTH-1:0] in_data,
  output logic out_valid,
  input wire logic out_ready,
  output logic [WIDTH-1:0] out_data
);
  localparam int AW = $clog2(DEPTH);

  logic [WIDTH-1:0] mem_q [DEPTH];
  logic [AW-1:0] wr_ptr_q;
  logic [AW-1:0] rd_ptr_q;
  logic [AW:0] count_q;
  logic push;
  logic pop;

  assign in_ready = (count_q != (AW+1)'(DEPTH));
  assign out_valid = (count_q != '0);
  assign out_data = mem_q[rd_ptr_q];
  assign push = in_valid && in_ready;
  assign pop = out_valid && out_ready;

  always_ff @(posedge clk) begin
    if (push) begin
      mem_q[wr_ptr_q] <= in_data;
    end
  end

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      wr_ptr_q <= '0;
      rd_ptr_q <= '0;
      count_q <= '0;
    end else begin
      if (push) begin
        wr_ptr_q <= (wr_ptr_q == AW'(DEPTH-1)) ? '0 : wr_ptr_q + 1'b1;
      end
      if (pop) begin
        rd_ptr_q <= (rd_ptr_q == AW'(DEPTH-1)) ? '0 : rd_ptr_q + 1'b1;
      end
      if (push && !pop) begin
        count_q <= count_q + 1'b1;
      end else if (pop && !push) begin
        count_q <= count_q - 1'b1;
      end
    end
  end
endmodule

// ---- hdl/rtu_frame_cfg.svh ----
// constants for the rtu slave frame handler
`ifndef RTU_FRAME_CFG_SVH
`define RTU_FRAME_CFG_SVH

`define RTU_ADDR_BCAST 8'h00
`define RTU_ADDR_MAX 8'hf7

`define RTU_FC_RD_HOLD 8'h03
`define RTU_FC_WR_ONE 8'h06
`define RTU_FC_DIAG 8'h08
`define RTU_FC_WR_MULTI 8'h10
`define RTU_FC_ACC_LOG 8'h46
`define RTU_FC_ERR_FLAG 8'h80
`define RTU_EXC_ILL_FUNC 8'h01

`define RTU_CRC_INIT 16'hffff
`define RTU_CRC_POLY 16'ha001
`define RTU_CRC_RESIDUE 16'h0000

`define RTU_MIN_FRAME 8'h04
`define RTU_FRAME_CNT_MAX 8'hff

`define RTU_CLK_HZ 100000000
`define RTU_BITS_PER_CHAR 11
`define RTU_IDLE_GAP_HALF_CHARS 7
`define RTU_BAUD_DFLT 9600

`define RTU_PAY_WIDTH 9
`define RTU_PAY_DEPTH 8

`endif

// ---- hdl/rtu_frame_handler.sv ----
// rtu slave frame handler: address/function decode, response framing, crc
`timescale 1ns/100ps
`include "rtu_frame_cfg.svh"
module rtu_frame_handler #(
  parameter int unsigned BAUD_RATE = `RTU_BAUD_DFLT,
  parameter int unsigned IDLE_GAP_CYCLES = 32'((64'(`RTU_IDLE_GAP_HALF_CHARS) * 64'(`RTU_BITS_PER_CHAR)
    * 64'(`RTU_CLK_HZ) + 64'(2 * BAUD_RATE) - 64'd1) / 64'(2 * BAUD_RATE))
) (
  input wire logic core_clk,
  input wire logic rst_b,
  input wire logic [7:0] station_number_setting,
  input wire logic rx_byte_valid,
  input wire logic [7:0] rx_byte,
  input wire logic rx_fault,
  output logic rx_data_valid,
  output logic [7:0] rx_data,
  output logic qry_valid,
  output rtu_pkg::rtu_op_e qry_op,
  output logic qry_bcast,
  output logic [7:0] qry_func,
  output logic frame_drop,
  output logic resp_pend,
  input wire logic resp_go,
  input wire logic resp_err,
  input wire logic pay_valid,
  input wire logic [7:0] pay_data,
  input wire logic pay_last,
  output logic pay_ready,
  output logic tx_valid,
  output logic [7:0] tx_data,
  input wire logic tx_ready,
  output logic tx_active
);
  import rtu_pkg::*;

  function automatic logic [15:0] crc_step(input logic [15:0] crc, input logic [7:0] b);
    logic [15:0] r;
    r = crc ^ {8'h00, b};
    for (int i = 0; i < 8; i++) begin
      r = r[0] ? ((r >> 1) ^ `RTU_CRC_POLY) : (r >> 1);
    end
    return r;
  endfunction

  // anything outside the five supported codes decodes to none and earns an error reply when addressed to this station; broadcasts are dropped
  function automatic rtu_op_e decode_op(input logic [7:0] fc);
    unique case (fc)
      `RTU_FC_RD_HOLD: return RTU_OP_RD_HOLD;
      `RTU_FC_WR_ONE: return RTU_OP_WR_ONE;
      `RTU_FC_DIAG: return RTU_OP_DIAG;
      `RTU_FC_WR_MULTI: return RTU_OP_WR_MULTI;
      `RTU_FC_ACC_LOG: return RTU_OP_ACC_LOG;
      default: return RTU_OP_NONE;
    endcase
  endfunction

  // reset falls asynchronously but leaves through two flops, so no flop sees a ragged release
  logic rst_meta_q;
  logic rst_sync_q;

  always_ff @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      rst_meta_q <= 1'b0;
      rst_sync_q <= 1'b0;
    end else begin
      rst_meta_q <= 1'b1;
      rst_sync_q <= rst_meta_q;
    end
  end

  // receive side state
  rtu_rx_st_e rx_st_q;
  logic [31:0] gap_cnt_q;
  logic gap_full;
  logic rx_evt;
  logic [7:0] cnt_q;
  logic [15:0] rx_crc_q;
  logic bad_q;
  logic [7:0] addr_q;
  logic [7:0] func_q;
  logic [7:0] hold0_q;
  logic [7:0] hold1_q;
  logic addr_ok;
  logic is_bcast;
  logic is_match;
  logic frame_end;
  logic frame_good;
  rtu_op_e op;
  logic bcast_ok;
  logic exec_bcast;
  logic exec_uni;
  logic auto_err;

  // transmit side state
  rtu_tx_st_e tx_st_q;
  logic [15:0] tx_crc_q;
  logic tx_err_q;
  logic tx_auto_q;
  logic tx_start;
  logic tx_ld;
  logic [7:0] tx_next;
  logic fifo_out_valid;
  logic [8:0] fifo_out_data;
  logic fifo_pop;

  assign rx_evt = rx_byte_valid || rx_fault;
  assign gap_full = (gap_cnt_q == IDLE_GAP_CYCLES);

  // the uart may still be shifting our last byte when tx_active drops, so the
  // gap after a reply is measured from handover, not from the line
  always_ff @(posedge core_clk or negedge rst_sync_q) begin
    if (!rst_sync_q) begin
      gap_cnt_q <= '0;
    end else if (rx_evt || tx_active) begin
      gap_cnt_q <= '0;
    end else if (!gap_full) begin
      gap_cnt_q <= gap_cnt_q + 32'h1;
    end
  end

  // a frame only opens after a full idle gap, so joining the line in the middle of
  // someone else's traffic cannot misalign the address and function fields
  always_ff @(posedge core_clk or negedge rst_sync_q) begin
    if (!rst_sync_q) begin
      rx_st_q <= RTU_RX_HUNT;
    end else if (tx_active) begin
      rx_st_q <= RTU_RX_HUNT; // half duplex: ignore the line while replying
    end else begin
      unique case (rx_st_q)
        RTU_RX_HUNT: begin
          if (gap_full) begin
            rx_st_q <= RTU_RX_IDLE;
          end
        end
        RTU_RX_IDLE: begin
          if (rx_evt) begin
            rx_st_q <= RTU_RX_FRAME;
          end
        end
        RTU_RX_FRAME: begin
          if (gap_full) begin
            rx_st_q <= RTU_RX_IDLE;
          end
        end
      endcase
    end
  end

  assign addr_ok = (addr_q <= `RTU_ADDR_MAX);
  assign is_bcast = (addr_q == `RTU_ADDR_BCAST);
  assign is_match = addr_ok && !is_bcast && (addr_q == station_number_setting);
  assign frame_end = (rx_st_q == RTU_RX_FRAME) && gap_full && !tx_active;
  // crc over the whole frame including its trailer leaves a zero residue
  assign frame_good = !bad_q && addr_ok && (cnt_q >= `RTU_MIN_FRAME)
    && (rx_crc_q == `RTU_CRC_RESIDUE);
  assign op = decode_op(func_q);
  // only the two write codes make sense without a reply; other broadcasts are dropped
  assign bcast_ok = (op == RTU_OP_WR_ONE) || (op == RTU_OP_WR_MULTI);
  assign exec_bcast = frame_end && frame_good && is_bcast && bcast_ok;
  assign exec_uni = frame_end && frame_good && is_match && (op != RTU_OP_NONE);
  assign auto_err = frame_end && frame_good && is_match && (op == RTU_OP_NONE);

  always_ff @(posedge core_clk or negedge rst_sync_q) begin
    if (!rst_sync_q) begin
      cnt_q <= '0;
      rx_crc_q <= `RTU_CRC_INIT;
      bad_q <= 1'b0;
      addr_q <= '0;
      func_q <= '0;
      hold0_q <= '0;
      hold1_q <= '0;
    end else if (!tx_active && rx_evt && (rx_st_q != RTU_RX_HUNT)) begin
      if (rx_st_q == RTU_RX_IDLE) begin
        cnt_q <= 8'h01;
        rx_crc_q <= crc_step(`RTU_CRC_INIT, rx_byte);
        bad_q <= rx_fault;
        addr_q <= rx_byte;
      end else begin
        if (cnt_q != `RTU_FRAME_CNT_MAX) begin
          cnt_q <= cnt_q + 8'h01;
        end
        rx_crc_q <= crc_step(rx_crc_q, rx_byte);
        bad_q <= bad_q || rx_fault;
        if (cnt_q == 8'h01) begin
          func_q <= rx_byte;
        end else if (cnt_q == 8'h02) begin
          hold0_q <= rx_byte;
        end else if (cnt_q == 8'h03) begin
          hold1_q <= rx_byte;
        end else begin
          hold0_q <= hold1_q; // the last two bytes are the trailer, never payload
          hold1_q <= rx_byte;
        end
      end
    end
  end

  // payload bytes are forwarded two bytes late so the trailer never leaks out
  always_ff @(posedge core_clk or negedge rst_sync_q) begin
    if (!rst_sync_q) begin
      rx_data_valid <= 1'b0;
      rx_data <= '0;
    end else begin
      rx_data_valid <= !tx_active && rx_byte_valid && (rx_st_q == RTU_RX_FRAME)
        && (cnt_q >= 8'h04) && (is_bcast || is_match);
      if (rx_byte_valid && (rx_st_q == RTU_RX_FRAME) && (cnt_q >= 8'h04)) begin
        rx_data <= hold0_q;
      end
    end
  end

  // op, broadcast and function stay put until the next frame end for the application
  always_ff @(posedge core_clk or negedge rst_sync_q) begin
    if (!rst_sync_q) begin
      qry_valid <= 1'b0;
      qry_op <= RTU_OP_NONE;
      qry_bcast <= 1'b0;
      qry_func <= '0;
      frame_drop <= 1'b0;
    end else begin
      qry_valid <= exec_bcast || exec_uni;
      frame_drop <= frame_end && !(exec_bcast || exec_uni);
      if (frame_end) begin
        qry_op <= op;
        qry_bcast <= is_bcast;
        qry_func <= func_q;
      end
    end
  end

  // a reply waits for the application; a new frame means the master moved on
  always_ff @(posedge core_clk or negedge rst_sync_q) begin
    if (!rst_sync_q) begin
      resp_pend <= 1'b0;
    end else if (exec_uni) begin
      resp_pend <= 1'b1;
    end else if (resp_go || (rx_evt && rx_st_q == RTU_RX_IDLE)) begin
      resp_pend <= 1'b0;
    end
  end

  assign tx_start = (tx_st_q == RTU_TX_IDLE) && (auto_err || (resp_pend && resp_go));
  assign tx_ld = (tx_st_q != RTU_TX_IDLE) && (!tx_valid || tx_ready)
    && ((tx_st_q != RTU_TX_PAY) || fifo_out_valid);
  assign fifo_pop = tx_ld && (tx_st_q == RTU_TX_PAY);
  assign tx_active = (tx_st_q != RTU_TX_IDLE) || tx_valid;

  // reply byte mux; the crc bytes come from the running sum before it moves on
  always_comb begin
    tx_next = 8'h00;
    unique case (tx_st_q)
      RTU_TX_IDLE: tx_next = 8'h00;
      RTU_TX_ADDR: tx_next = addr_q;
      RTU_TX_FUNC: tx_next = tx_err_q ? (func_q | `RTU_FC_ERR_FLAG) : func_q;
      RTU_TX_PAY: tx_next = fifo_out_data[7:0];
      RTU_TX_EXC: tx_next = `RTU_EXC_ILL_FUNC;
      RTU_TX_CRCL: tx_next = tx_crc_q[7:0];
      RTU_TX_CRCH: tx_next = tx_crc_q[15:8];
    endcase
  end

  always_ff @(posedge core_clk or negedge rst_sync_q) begin
    if (!rst_sync_q) begin
      tx_st_q <= RTU_TX_IDLE;
      tx_err_q <= 1'b0;
      tx_auto_q <= 1'b0;
    end else if (tx_start) begin
      tx_st_q <= RTU_TX_ADDR;
      tx_err_q <= auto_err || resp_err;
      tx_auto_q <= auto_err;
    end else if (tx_ld) begin
      unique case (tx_st_q)
        RTU_TX_IDLE: tx_st_q <= RTU_TX_IDLE;
        RTU_TX_ADDR: tx_st_q <= RTU_TX_FUNC;
        RTU_TX_FUNC: tx_st_q <= tx_auto_q ? RTU_TX_EXC : RTU_TX_PAY;
        RTU_TX_PAY: tx_st_q <= fifo_out_data[8] ? RTU_TX_CRCL : RTU_TX_PAY;
        RTU_TX_EXC: tx_st_q <= RTU_TX_CRCL;
        RTU_TX_CRCL: tx_st_q <= RTU_TX_CRCH;
        RTU_TX_CRCH: tx_st_q <= RTU_TX_IDLE;
      endcase
    end
  end

  // the trailer bytes must not be folded into the sum that they carry
  always_ff @(posedge core_clk or negedge rst_sync_q) begin
    if (!rst_sync_q) begin
      tx_crc_q <= `RTU_CRC_INIT;
    end else if (tx_start) begin
      tx_crc_q <= `RTU_CRC_INIT;
    end else if (tx_ld && (tx_st_q != RTU_TX_CRCL) && (tx_st_q != RTU_TX_CRCH)) begin
      tx_crc_q <= crc_step(tx_crc_q, tx_next);
    end
  end

  // a byte stays offered until the uart takes it; the next one follows back to back
  always_ff @(posedge core_clk or negedge rst_sync_q) begin
    if (!rst_sync_q) begin
      tx_valid <= 1'b0;
      tx_data <= '0;
    end else if (tx_ld) begin
      tx_valid <= 1'b1;
      tx_data <= tx_next;
    end else if (tx_ready) begin
      tx_valid <= 1'b0;
    end
  end

  // payload may be queued ahead of resp_go; a full queue stalls the application
  rtu_fifo #(
    .WIDTH(`RTU_PAY_WIDTH),
    .DEPTH(`RTU_PAY_DEPTH)
  ) u_pay_fifo (
    .clk(core_clk),
    .rst_b(rst_sync_q),
    .in_valid(pay_valid),
    .in_ready(pay_ready),
    .in_data({pay_last, pay_data}),
    .out_valid(fifo_out_valid),
    .out_ready(fifo_pop),
    .out_data(fifo_out_data)
  );
endmodule

// ---- hdl/rtu_pkg.sv ----
// types shared by the rtu slave frame handler
package rtu_pkg;

  typedef enum logic [5:0] {
    RTU_OP_NONE = 6'h01,
    RTU_OP_RD_HOLD = 6'h02,
    RTU_OP_WR_ONE = 6'h04,
    RTU_OP_DIAG = 6'h08,
    RTU_OP_WR_MULTI = 6'h10,
    RTU_OP_ACC_LOG = 6'h20
  } rtu_op_e;

  typedef enum logic [2:0] {
    RTU_RX_HUNT = 3'h1,
    RTU_RX_IDLE = 3'h2,
    RTU_RX_FRAME = 3'h4
  } rtu_rx_st_e;

  typedef enum logic [6:0] {
    RTU_TX_IDLE = 7'h01,
    RTU_TX_ADDR = 7'h02,
    RTU_TX_FUNC = 7'h04,
    RTU_TX_PAY = 7'h08,
    RTU_TX_EXC = 7'h10,
    RTU_TX_CRCL = 7'h20,
    RTU_TX_CRCH = 7'h40
  } rtu_tx_st_e;

endpackage

// ---- verif/rtu_frame_handler_assertions.sv ----
// checker bound to the rtu frame handler ports
`timescale 1ns/100ps
module rtu_frame_handler_assertions (
  input wire logic core_clk,
  input wire logic rst_b,
  input wire logic qry_valid,
  input wire rtu_pkg::rtu_op_e qry_op,
  input wire logic qry_bcast,
  input wire logic [7:0] qry_func,
  input wire logic frame_drop,
  input wire logic resp_pend,
  input wire logic resp_go,
  input wire logic tx_valid,
  input wire logic [7:0] tx_data,
  input wire logic tx_ready,
  input wire logic tx_active
);
  import rtu_pkg::*;
  logic [7:0] idx_q;
  // byte index within a reply, so the function byte can be picked out
  always_ff @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      idx_q <= 8'h00;
    end else if (!tx_active) begin
      idx_q <= 8'h00;
    end else if (tx_valid && tx_ready) begin
      idx_q <= idx_q + 8'h01;
    end
  end
  default clocking @(posedge core_clk);
  endclocking
  default disable iff (!rst_b);
  one_outcome_a:
    assert property (qry_valid |-> !frame_drop) else $error("frame both accepted and dropped");
  tx_hold_a:
    assert property (tx_valid && !tx_ready |=> tx_valid && $stable(tx_data)) else $error("reply byte not held");
  reply_start_a:
    assert property (resp_go && resp_pend && !tx_active |-> ##[1:3] tx_valid) else $error("reply did not start");
  func_echo_a:
    assert property (tx_valid && idx_q == 8'h01 |-> tx_data[6:0] == qry_func[6:0]) else $error("function byte wrong");
  unsup_flag_a:
    assert property (tx_valid && idx_q == 8'h01 && qry_op == RTU_OP_NONE |-> tx_data[7]) else $error("error flag missing");
  ucast_pend_a:
    assert property (qry_valid && !qry_bcast |-> ##[0:1] resp_pend) else $error("no reply pending");
  bcast_codes_a:
    assert property (qry_valid && qry_bcast |-> qry_func == 8'h06 || qry_func == 8'h10) else $error("bad broadcast");
  bcast_silent_a:
    assert property (qry_valid && qry_bcast |=> !tx_active [*8]) else $error("broadcast answered");
  cover property (qry_valid && qry_bcast);
  cover property (frame_drop);
  cover property (tx_valid && !tx_ready);
endmodule

bind rtu_frame_handler rtu_frame_handler_assertions u_chk (.core_clk(core_clk), .rst_b(rst_b), .qry_valid(qry_valid),
  .qry_op(qry_op), .qry_bcast(qry_bcast), .qry_func(qry_func), .frame_drop(frame_drop), .resp_pend(resp_pend),
  .resp_go(resp_go), .tx_valid(tx_valid), .tx_data(tx_data), .tx_ready(tx_ready), .tx_active(tx_active));

// ---- verif/rtu_frame_handler_test.sv ----
// self-checking bench for the rtu slave frame handler
`timescale 1ns/100ps
module rtu_frame_handler_test;
  import rtu_pkg::*;
  localparam int GAP = 20;
  logic core_clk = 1'b0;
  logic rst_b = 1'b0;
  logic [7:0] station_number_setting = 8'h11;
  logic resp_go = 1'b0;
  logic resp_err = 1'b0;
  logic pay_valid = 1'b0;
  logic pay_last = 1'b0;
  logic [7:0] pay_data = 8'h00;
  logic rx_byte_valid, rx_fault, rx_data_valid, qry_valid, qry_bcast, frame_drop, resp_pend;
  logic pay_ready, tx_valid, tx_ready, tx_active;
  logic [7:0] rx_byte, rx_data, qry_func, tx_data;
  rtu_op_e qry_op;
  logic [7:0] rxq[$];
  logic [7:0] fc[5] = '{8'h03, 8'h06, 8'h08, 8'h10, 8'h46};
  int errors = 0;
  int comparisons = 0;
  int cycles = 0;
  always #5 core_clk = ~core_clk;
  rtu_frame_handler #(.IDLE_GAP_CYCLES(GAP)) dut (.core_clk(core_clk), .rst_b(rst_b),
    .station_number_setting(station_number_setting), .rx_byte_valid(rx_byte_valid), .rx_byte(rx_byte),
    .rx_fault(rx_fault), .rx_data_valid(rx_data_valid), .rx_data(rx_data), .qry_valid(qry_valid), .qry_op(qry_op),
    .qry_bcast(qry_bcast), .qry_func(qry_func), .frame_drop(frame_drop), .resp_pend(resp_pend), .resp_go(resp_go),
    .resp_err(resp_err), .pay_valid(pay_valid), .pay_data(pay_data), .pay_last(pay_last), .pay_ready(pay_ready),
    .tx_valid(tx_valid), .tx_data(tx_data), .tx_ready(tx_ready), .tx_active(tx_active));
  rtu_master_model u_master (.core_clk(core_clk), .rx_byte_valid(rx_byte_valid), .rx_byte(rx_byte),
    .rx_fault(rx_fault), .tx_valid(tx_valid), .tx_data(tx_data), .tx_ready(tx_ready));
  task automatic wrap_up;
    $display("errors %0d comparisons %0d", errors, comparisons);
    if (errors == 0 && comparisons > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask
  // the run should need about a thousand cycles; a hang ends here
  always @(posedge core_clk) begin
    cycles++;
    if (rx_data_valid) rxq.push_back(rx_data);
    if (cycles == 20000) begin
      errors++;
      wrap_up();
    end
  end
  task automatic check(input string what, input logic [15:0] exp, input logic [15:0] seen);
    comparisons++;
    if (seen !== exp) begin
      errors++;
      $display("mismatch %s expected %h seen %h", what, exp, seen);
    end
  endtask
  function automatic rtu_op_e op_of(input logic [7:0] f);
    case (f)
      8'h03: return RTU_OP_RD_HOLD;
      8'h06: return RTU_OP_WR_ONE;
      8'h08: return RTU_OP_DIAG;
      8'h10: return RTU_OP_WR_MULTI;
      8'h46: return RTU_OP_ACC_LOG;
      default: return RTU_OP_NONE;
    endcase
  endfunction
  task automatic query(input logic [7:0] a, input logic [7:0] f, input int bad, input logic [15:0] flip, input logic ok);
    logic [7:0] b[$];
    b = '{a, f, 8'h12, f ^ 8'h5a};
    rxq.delete();
    u_master.got.delete();
    u_master.send(b, bad, flip);
    for (int n = 0; n < 3 * GAP && !(qry_valid || frame_drop); n++) @(negedge core_clk);
    check("accepted", 16'(ok), 16'(qry_valid));
    check("dropped", 16'(!ok), 16'(frame_drop));
    if (ok) begin
      check("op", 16'(op_of(f)), 16'(qry_op));
      check("func", 16'(f), 16'(qry_func));
      check("broadcast", 16'(a == 8'h00), 16'(qry_bcast));
      check("payload", {8'h12, f ^ 8'h5a}, {rxq[0], rxq[1]});
    end
    repeat (GAP) @(negedge core_clk);
  endtask
  task automatic finish(input logic [7:0] e[$]);
    logic [15:0] c;
    c = u_master.crc16(e);
    e.push_back(c[7:0]);
    e.push_back(c[15:8]);
    for (int n = 0; n < 400 && u_master.got.size() < e.size(); n++) @(negedge core_clk);
    repeat (GAP + 4) @(negedge core_clk);
    check("reply length", 16'(e.size()), 16'(u_master.got.size()));
    foreach (e[i]) check("reply byte", 16'(e[i]), 16'(u_master.got[i]));
  endtask
  task automatic reply(input logic err, input logic [7:0] a, input logic [7:0] fe, input logic [7:0] p[$]);
    logic [7:0] e[$];
    logic full;
    e = p;
    e.push_front(fe);
    e.push_front(a);
    full = 1'b0;
    check("pending", 16'h0001, 16'(resp_pend));
    resp_err = err;
    resp_go = 1'b1;
    @(negedge core_clk);
    resp_go = 1'b0;
    foreach (p[i]) begin
      pay_valid = 1'b1;
      pay_data = p[i];
      pay_last = (i == p.size() - 1);
      while (!pay_ready) begin
        full = 1'b1;
        @(negedge core_clk);
      end
      @(negedge core_clk);
    end
    pay_valid = 1'b0;
    pay_last = 1'b0;
    finish(e);
    if (p.size() > 8) check("fifo refused", 16'h0001, 16'(full));
  endtask
  initial begin
    logic [7:0] p[$];
    repeat (16) @(negedge core_clk);
    rst_b = 1'b1;
    repeat (GAP + 6) @(negedge core_clk);
    check("fifo ready", 16'h0001, 16'(pay_ready));
    for (int i = 0; i < 12; i++) p.push_back(8'(i * 19));
    u_master.slow = 1'b1;
    query(8'h11, 8'h03, -1, 16'h0000, 1'b1);
    reply(1'b0, 8'h11, 8'h03, p);
    u_master.slow = 1'b0;
    query(8'h11, 8'h46, -1, 16'h0000, 1'b1);
    reply(1'b1, 8'h11, 8'hc6, '{8'h03});
    foreach (fc[i]) query(8'h11, fc[i], -1, 16'h0000, 1'b1);
    foreach (fc[i]) begin
      query(8'h00, fc[i], -1, 16'h0000, fc[i] == 8'h06 || fc[i] == 8'h10);
      check("silent", 16'h0000, 16'(u_master.got.size()));
    end
    query(8'h11, 8'h2b, -1, 16'h0000, 1'b0);
    finish('{8'h11, 8'hab, 8'h01});
    query(8'h11, 8'h06, -1, 16'h0001, 1'b0);
    query(8'h11, 8'h06, 2, 16'h0000, 1'b0);
    query(8'h12, 8'h06, -1, 16'h0000, 1'b0);
    query(8'hf8, 8'h06, -1, 16'h0000, 1'b0);
    check("silent", 16'h0000, 16'(u_master.got.size()));
    station_number_setting = 8'hf7;
    query(8'hf7, 8'h10, -1, 16'h0000, 1'b1);
    wrap_up();
  end
endmodule

// ---- verif/rtu_master_model.sv ----
// serial bus master model: sends queries, takes reply bytes
`timescale 1ns/100ps
module rtu_master_model (
  input wire logic core_clk,
  output logic rx_byte_valid,
  output logic [7:0] rx_byte,
  output logic rx_fault,
  input wire logic tx_valid,
  input wire logic [7:0] tx_data,
  output logic tx_ready
);
  logic [7:0] got[$];
  logic slow = 1'b0;
  logic [1:0] ph = 2'h0;
  initial begin
    rx_byte_valid = 1'b0;
    rx_byte = 8'h00;
    rx_fault = 1'b0;
    tx_ready = 1'b0;
  end
  // a slow master is ready one cycle in three so the reply path must hold
  always @(negedge core_clk) begin
    ph <= (ph == 2'h2) ? 2'h0 : ph + 2'h1;
    tx_ready <= !slow || ph == 2'h2;
  end
  always @(posedge core_clk) begin
    if (tx_valid && tx_ready) got.push_back(tx_data);
  end
  function automatic logic [15:0] crc16(input logic [7:0] b[$]);
    logic [15:0] c;
    c = 16'hffff;
    foreach (b[i]) begin
      c = c ^ {8'h00, b[i]};
      for (int k = 0; k < 8; k++) c = c[0] ? (c >> 1) ^ 16'ha001 : c >> 1;
    end
    return c;
  endfunction
  // bytes go back to back, far shorter than the frame gap; idle line shows the inverse
  task automatic send(input logic [7:0] b[$], input int bad, input logic [15:0] flip);
    logic [15:0] c;
    c = crc16(b) ^ flip;
    b.push_back(c[7:0]);
    b.push_back(c[15:8]);
    foreach (b[i]) begin
      @(negedge core_clk);
      rx_byte_valid = 1'b1;
      rx_byte = b[i];
      rx_fault = (i == bad);
    end
    @(negedge core_clk);
    rx_byte_valid = 1'b0;
    rx_fault = 1'b0;
    rx_byte = ~rx_byte;
  endtask
endmodule
